// ==== hw/fls_sequencer_defs.vh ====
/*
  Constants for the serial flash command sequencer: opcodes, geometry,
  protection levels and self-timed cycle lengths.
  Assumes it is included by the sequencer module and the bench top, by bare name.
*/
`ifndef FLS_SEQUENCER_DEFS_VH
`define FLS_SEQUENCER_DEFS_VH

// ****************************************
// Opcodes
// ****************************************
`define FLS_OP_WRITE_ARM 8'h06
`define FLS_OP_SMALL_WIPE 8'h20
`define FLS_OP_LARGE_WIPE 8'hd8
`define FLS_OP_FULL_WIPE 8'h60
`define FLS_OP_PAGE_WRITE 8'h02
`define FLS_OP_SLEEP_ENTRY 8'hb9
`define FLS_OP_SLEEP_EXIT 8'hab
`define FLS_OP_MAKER_PART_ID 8'h90
`define FLS_SWAP_ADDR 8'h01

// ****************************************
// Geometry and protection
// ****************************************
`define FLS_ADDR_BITS 17
`define FLS_PAGE_BITS 8
`define FLS_SECTOR_BITS 12
`define FLS_BLOCK_BITS 16
`define FLS_PROT_NONE 2'h0
`define FLS_PROT_QUARTER 2'h1
`define FLS_PROT_HALF 2'h2

// ****************************************
// Times in microseconds, clock rate in MHz
// ****************************************
`define FLS_CLK_MHZ 40
`define FLS_SMALL_WIPE_US 1000
`define FLS_LARGE_WIPE_US 2000
`define FLS_FULL_WIPE_US 4000
`define FLS_PAGE_WRITE_US 500
`define FLS_SLEEP_ENTRY_US 3
`define FLS_WAKE_US 8
`define FLS_SLEEP_ENTRY_CYC (`FLS_SLEEP_ENTRY_US * `FLS_CLK_MHZ)
`define FLS_WAKE_CYC (`FLS_WAKE_US * `FLS_CLK_MHZ)

`endif

// ==== hw/fls_sequencer.v ====
/*
  Serial flash command sequencer: wipes, page write, deep sleep entry and
  exit, signature and maker/part code reads, with its own byte array.
  Assumes an SPI host in mode 0 or 3 whose clock is at most 1/8 of core_clk.
*/
`timescale 1ns/1ps
`include "fls_sequencer_defs.vh"

module fls_sequencer #(
  parameter AW = `FLS_ADDR_BITS,
  parameter [7:0] SIGNATURE = 8'h5a,   // Arbitrary value
  parameter [7:0] MAKER_CODE = 8'ha5,  // Arbitrary value
  parameter [7:0] PART_CODE = 8'h3c,   // Arbitrary value
  parameter [31:0] SMALL_WIPE_CYC = `FLS_SMALL_WIPE_US * `FLS_CLK_MHZ,
  parameter [31:0] LARGE_WIPE_CYC = `FLS_LARGE_WIPE_US * `FLS_CLK_MHZ,
  parameter [31:0] FULL_WIPE_CYC = `FLS_FULL_WIPE_US * `FLS_CLK_MHZ,
  parameter [31:0] PAGE_WRITE_CYC = `FLS_PAGE_WRITE_US * `FLS_CLK_MHZ
) (
  input wire core_clk,
  input wire rst_n,
  input wire chipSelectN,            // SPI select pin
  input wire serialClk,              // SPI clock pin
  input wire serialIn,               // SPI data in pin
  output reg serialOut,              // SPI data out
  output reg serialOutEn,            // High while driving serialOut
  input wire protectLevelHi,         // Held protect level bits
  input wire protectLevelLo,
  output reg operationBusyFlag,
  output reg writeArmedFlag,
  output reg deepSleep,              // Deep power-down reached
  input wire [AW-1:0] peekAddr,      // Array inspection port
  output reg [7:0] peekData
);

  // ****************************************
  // Local constants and states
  // ****************************************
  localparam PS_STANDBY = 4'b0001;
  localparam PS_ENTERING = 4'b0010;
  localparam PS_DEEP = 4'b0100;
  localparam PS_WAKING = 4'b1000;
  localparam OS_IDLE = 3'b001;
  localparam OS_WAIT = 3'b010;
  localparam OS_WALK = 3'b100;
  localparam [31:0] SLEEP_CYC = `FLS_SLEEP_ENTRY_CYC;
  localparam [31:0] WAKE_CYC = `FLS_WAKE_CYC;
  localparam [AW:0] MEM_BYTES = {1'b1, {AW{1'b0}}};
  localparam [AW:0] PAGE_LEN = {{(AW-`FLS_PAGE_BITS){1'b0}}, 1'b1, {`FLS_PAGE_BITS{1'b0}}};
  localparam [AW:0] SECTOR_LEN = {{(AW-`FLS_SECTOR_BITS){1'b0}}, 1'b1, {`FLS_SECTOR_BITS{1'b0}}};
  localparam [AW:0] BLOCK_LEN = {{(AW-`FLS_BLOCK_BITS){1'b0}}, 1'b1, {`FLS_BLOCK_BITS{1'b0}}};

  // ****************************************
  // Storage
  // ****************************************
  reg [7:0] mem [0:(1<<AW)-1];       // The flash array itself
  reg [7:0] pageBuf [0:255];         // Page data waiting to be written
  reg [255:0] pageMask;              // Columns received in this page write

  // ****************************************
  // Pin synchronisers and edge finding
  // ****************************************
  reg [2:0] syncA;                   // First stage, read only by syncB
  reg [2:0] syncB;                   // Second stage: {cs, clk, data}
  reg [1:0] prevB;                   // Previous cs and clk for edges
  wire csN = syncB[2];
  wire sclkRise = syncB[1] & ~prevB[0];
  wire sclkFall = ~syncB[1] & prevB[0];
  wire csFall = ~csN & prevB[1];
  wire csRise = csN & ~prevB[1];
  wire sdi = syncB[0];

  // Two flops on every SPI pin before any logic looks at it
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 3'h7;
      syncB <= 3'h7;
      prevB <= 2'h3;
    end else begin
      syncA <= {chipSelectN, serialClk, serialIn};
      syncB <= syncA;
      prevB <= syncB[2:1];
    end
  end

  // ****************************************
  // Frame state
  // ****************************************
  reg [7:0] shiftIn;                 // Incoming bits of the current byte
  reg [2:0] bitInByte;               // Bits taken of the current byte
  reg [2:0] byteIdx;                 // Bytes taken, saturates at 7
  reg [7:0] opcode;
  reg [23:0] addr;
  reg [7:0] pageCol;                 // Next page column to fill
  reg pageOpen;                      // Page data is being collected
  reg outOn;                         // Code output phase reached
  reg [7:0] outShift;                // Outgoing code byte
  reg [2:0] outCnt;
  reg partLoaded;                    // Part code is the byte in outShift
  reg idShown;                       // A whole code byte has gone out
  reg [3:0] pState;
  reg [15:0] pTimer;
  reg [2:0] oState;
  reg [31:0] oTimer;
  reg isProgram;
  reg [AW-1:0] opBase;
  reg [AW:0] opLen;
  reg [AW:0] walkIdx;

  wire [7:0] byteNow = {shiftIn[6:0], sdi};
  wire asleep = ~pState[0];
  wire [1:0] protLevel = {protectLevelHi, protectLevelLo};
  wire exact8 = (byteIdx == 3'd1) && (bitInByte == 3'd0);
  wire exact32 = (byteIdx == 3'd4) && (bitInByte == 3'd0);
  wire dataEnd = (byteIdx >= 3'd5) && (bitInByte == 3'd0);
  wire canWrite = writeArmedFlag & ~operationBusyFlag & ~asleep;
  wire [AW-1:0] tgt = addr[AW-1:0];

  // Protected area grows downward from the top of the array
  reg [AW:0] protBase;
  always @* begin
    case (protLevel)
      `FLS_PROT_NONE: protBase = MEM_BYTES;
      `FLS_PROT_QUARTER: protBase = MEM_BYTES - (MEM_BYTES >> 2);
      `FLS_PROT_HALF: protBase = MEM_BYTES >> 1;
      default: protBase = {(AW+1){1'b0}};
    endcase
  end

  // Last byte of each candidate region, sector taken from bit 12 up
  wire [AW-1:0] pageEnd = tgt | {{(AW-`FLS_PAGE_BITS){1'b0}}, {`FLS_PAGE_BITS{1'b1}}};
  wire [AW-1:0] sectEnd = tgt | {{(AW-`FLS_SECTOR_BITS){1'b0}}, {`FLS_SECTOR_BITS{1'b1}}};
  wire [AW-1:0] blockEnd = tgt | {{(AW-`FLS_BLOCK_BITS){1'b0}}, {`FLS_BLOCK_BITS{1'b1}}};
  wire pageProt = {1'b0, pageEnd} >= protBase;
  wire sectProt = {1'b0, sectEnd} >= protBase;
  wire blockProt = {1'b0, blockEnd} >= protBase;

  // Acceptance of each command at the rising select edge
  wire goSmall = csRise && opcode == `FLS_OP_SMALL_WIPE && exact32
    && canWrite && !sectProt;
  wire goLarge = csRise && opcode == `FLS_OP_LARGE_WIPE && exact32
    && canWrite && !blockProt;
  wire goFull = csRise && opcode == `FLS_OP_FULL_WIPE && exact8
    && canWrite && protLevel == `FLS_PROT_NONE;
  wire goPage = csRise && opcode == `FLS_OP_PAGE_WRITE && dataEnd
    && canWrite && pageOpen && !pageProt;
  wire goArm = csRise && opcode == `FLS_OP_WRITE_ARM && exact8
    && !operationBusyFlag && !asleep;
  wire goSleep = csRise && opcode == `FLS_OP_SLEEP_ENTRY && exact8
    && !operationBusyFlag && !asleep;
  wire goWake = csRise && opcode == `FLS_OP_SLEEP_EXIT && (exact8 || idShown)
    && !operationBusyFlag;
  wire opDone = oState[2] && (walkIdx == opLen - 1'b1);

  // ****************************************
  // Command shifter and page collection
  // ****************************************
  // Bits land on the rising serial clock, MSB first
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftIn <= 8'h00;
      bitInByte <= 3'h0;
      byteIdx <= 3'h0;
      opcode <= 8'h00;
      addr <= 24'h000000;
      pageCol <= 8'h00;
      pageOpen <= 1'b0;
      pageMask <= {256{1'b0}};
    end else if (csFall) begin
      // A new frame starts from byte zero
      bitInByte <= 3'h0;
      byteIdx <= 3'h0;
      pageOpen <= 1'b0;
    end else if (sclkRise && !csN) begin
      shiftIn <= byteNow;
      bitInByte <= bitInByte + 3'd1;
      if (bitInByte == 3'd7) begin
        if (byteIdx != 3'd7) begin
          byteIdx <= byteIdx + 3'd1;
        end
        case (byteIdx)
          3'd0: begin
            opcode <= byteNow;
          end
          3'd1: begin
            addr[23:16] <= byteNow;
          end
          3'd2: begin
            addr[15:8] <= byteNow;
          end
          3'd3: begin
            addr[7:0] <= byteNow;
            pageCol <= byteNow;
            // Mask is only cleared when no program walk reads it
            if (opcode == `FLS_OP_PAGE_WRITE && !operationBusyFlag) begin
              pageOpen <= 1'b1;
              pageMask <= {256{1'b0}};
            end
          end
          default: begin
            if (pageOpen) begin
              // Wrap inside the page; later bytes overwrite earlier ones
              pageBuf[pageCol] <= byteNow;
              pageMask[pageCol] <= 1'b1;
              pageCol <= pageCol + 8'd1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Code output on the falling serial clock
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outOn <= 1'b0;
      outShift <= 8'h00;
      outCnt <= 3'h0;
      partLoaded <= 1'b0;
      idShown <= 1'b0;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (csN) begin
      // Deselect releases the output
      outOn <= 1'b0;
      serialOutEn <= 1'b0;
      if (csFall) begin
        idShown <= 1'b0;
      end
    end else if (csFall) begin
      idShown <= 1'b0;
      outCnt <= 3'h0;
    end else if (sclkRise && bitInByte == 3'd7 && byteIdx == 3'd3) begin
      // After the fourth byte the code output begins
      outCnt <= 3'h0;
      if (opcode == `FLS_OP_MAKER_PART_ID && !asleep) begin
        outOn <= 1'b1;
        partLoaded <= (byteNow == `FLS_SWAP_ADDR);
        outShift <= (byteNow == `FLS_SWAP_ADDR) ? PART_CODE : MAKER_CODE;
      end else if (opcode == `FLS_OP_SLEEP_EXIT && !operationBusyFlag) begin
        outOn <= 1'b1;
        outShift <= SIGNATURE;
      end
    end else if (sclkFall && outOn) begin
      serialOutEn <= 1'b1;
      serialOut <= outShift[7];
      outCnt <= outCnt + 3'd1;
      if (outCnt == 3'd7) begin
        idShown <= 1'b1;
        if (opcode == `FLS_OP_MAKER_PART_ID) begin
          partLoaded <= ~partLoaded;
          outShift <= partLoaded ? MAKER_CODE : PART_CODE;
        end else begin
          outShift <= SIGNATURE;
        end
      end else begin
        outShift <= {outShift[6:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Power state: standby, entering, deep, waking
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pState <= PS_STANDBY;
      pTimer <= 16'h0000;
      deepSleep <= 1'b0;
    end else begin
      case (pState)
        PS_STANDBY: begin
          if (goSleep) begin
            pState <= PS_ENTERING;
            pTimer <= SLEEP_CYC[15:0] - 16'd1;
          end
        end
        PS_ENTERING: begin
          if (goWake) begin
            pState <= PS_STANDBY;
          end else if (pTimer == 16'h0000) begin
            pState <= PS_DEEP;
            deepSleep <= 1'b1;
          end else begin
            pTimer <= pTimer - 16'd1;
          end
        end
        PS_DEEP: begin
          if (goWake) begin
            pState <= PS_WAKING;
            pTimer <= WAKE_CYC[15:0] - 16'd1;
          end
        end
        PS_WAKING: begin
          if (pTimer == 16'h0000) begin
            pState <= PS_STANDBY;
            deepSleep <= 1'b0;
          end else begin
            pTimer <= pTimer - 16'd1;
          end
        end
        default: begin
          pState <= PS_STANDBY;
          deepSleep <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Self-timed cycles and flags
  // ****************************************
  // The wait models the cycle time; the walk then applies it one byte a
  // cycle, so each duration must exceed the region size in cycles.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oState <= OS_IDLE;
      oTimer <= 32'h00000000;
      isProgram <= 1'b0;
      opBase <= {AW{1'b0}};
      opLen <= {(AW+1){1'b0}};
      walkIdx <= {(AW+1){1'b0}};
      operationBusyFlag <= 1'b0;
      writeArmedFlag <= 1'b0;
    end else begin
      if (goArm) begin
        writeArmedFlag <= 1'b1;
      end
      case (oState)
        OS_IDLE: begin
          walkIdx <= {(AW+1){1'b0}};
          if (goSmall || goLarge || goFull || goPage) begin
            oState <= OS_WAIT;
            operationBusyFlag <= 1'b1;
            isProgram <= goPage;
          end
          if (goSmall) begin
            opBase <= tgt & ~(SECTOR_LEN[AW-1:0] - 1'b1);
            opLen <= SECTOR_LEN;
            oTimer <= SMALL_WIPE_CYC - 32'd1;
          end else if (goLarge) begin
            opBase <= tgt & ~(BLOCK_LEN[AW-1:0] - 1'b1);
            opLen <= BLOCK_LEN;
            oTimer <= LARGE_WIPE_CYC - 32'd1;
          end else if (goFull) begin
            opBase <= {AW{1'b0}};
            opLen <= MEM_BYTES;
            oTimer <= FULL_WIPE_CYC - 32'd1;
          end else if (goPage) begin
            opBase <= tgt & ~(PAGE_LEN[AW-1:0] - 1'b1);
            opLen <= PAGE_LEN;
            oTimer <= PAGE_WRITE_CYC - 32'd1;
          end
        end
        OS_WAIT: begin
          if (oTimer == 32'h00000000) begin
            oState <= OS_WALK;
          end else begin
            oTimer <= oTimer - 32'd1;
          end
        end
        OS_WALK: begin
          walkIdx <= walkIdx + 1'b1;
          if (opDone) begin
            oState <= OS_IDLE;
            operationBusyFlag <= 1'b0;
            writeArmedFlag <= 1'b0;
          end
        end
        default: begin
          oState <= OS_IDLE;
          operationBusyFlag <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Array writes and inspection port
  // ****************************************
  // Program can only clear bits; untouched columns keep their data
  wire [AW-1:0] walkAddr = opBase + walkIdx[AW-1:0];
  wire [7:0] walkCol = walkIdx[7:0];
  always @(posedge core_clk) begin
    if (oState[2]) begin
      if (!isProgram) begin
        mem[walkAddr] <= 8'hff;
      end else if (pageMask[walkCol]) begin
        mem[walkAddr] <= mem[walkAddr] & pageBuf[walkCol];
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peekData <= 8'h00;
    end else begin
      peekData <= mem[peekAddr];
    end
  end

endmodule // fls_sequencer

// ==== verification/fls_sequencer_asserts.sv ====
/*
  Port checker for the flash sequencer, bound to every instance.
  Assumes one core_clk domain and the async active-low rst_n.
*/
`timescale 1ns/1ps

module fls_sequencer_asserts #(
  parameter AW = 17,
  parameter [31:0] PAGE_WRITE_CYC = 32'h12c
) (
  input wire core_clk,
  input wire rst_n,
  input wire chipSelectN,
  input wire serialClk,
  input wire serialIn,
  input wire serialOut,
  input wire serialOutEn,
  input wire protectLevelHi,
  input wire protectLevelLo,
  input wire operationBusyFlag,
  input wire writeArmedFlag,
  input wire deepSleep,
  input wire [AW-1:0] peekAddr,
  input wire [7:0] peekData
);
  // Busy cycles so far; a page write is the shortest cycle
  logic [31:0] busyCount;
  // Restarts whenever busy is low
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCount <= 32'h0;
    end else begin
      busyCount <= operationBusyFlag ? busyCount + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****
  // Properties
  // ****
  a_busy_arm_drop: assert property ($fell(operationBusyFlag) |-> !writeArmedFlag)
    else $error("armed flag outlived the busy cycle");
  a_busy_min_len: assert property ($fell(operationBusyFlag) |-> busyCount >= PAGE_WRITE_CYC)
    else $error("busy cycle too short");
  a_busy_needs_arm: assert property ($rose(operationBusyFlag) |-> $past(writeArmedFlag))
    else $error("cycle started without armed flag");
  a_arm_when_idle: assert property ($rose(writeArmedFlag) |-> !$past(operationBusyFlag))
    else $error("arm taken while busy");
  a_busy_after_deselect: assert property ($rose(operationBusyFlag) |-> $past(chipSelectN, 2))
    else $error("cycle started while selected");
  a_no_wipe_asleep: assert property ($rose(operationBusyFlag) |-> !$past(deepSleep))
    else $error("cycle started in deep sleep");
  a_all_protected: assert property ($rose(operationBusyFlag) |->
    !($past(protectLevelHi) && $past(protectLevelLo)))
    else $error("cycle started with whole array shielded");
  // Output must be released a few clocks after deselect
  a_quiet_deselect: assert property (chipSelectN [*7] |-> !serialOutEn)
    else $error("data out driven while deselected");
endmodule // fls_sequencer_asserts

bind fls_sequencer fls_sequencer_asserts #(.AW(AW), .PAGE_WRITE_CYC(PAGE_WRITE_CYC))
  fls_sequencer_asserts_inst (.core_clk(core_clk), .rst_n(rst_n),
  .chipSelectN(chipSelectN), .serialClk(serialClk), .serialIn(serialIn),
  .serialOut(serialOut), .serialOutEn(serialOutEn), .protectLevelHi(protectLevelHi),
  .protectLevelLo(protectLevelLo), .operationBusyFlag(operationBusyFlag),
  .writeArmedFlag(writeArmedFlag), .deepSleep(deepSleep), .peekAddr(peekAddr),
  .peekData(peekData));

// ==== verification/fls_spi_host.sv ====
/*
  SPI host model in mode 0: framed transfers, optional broken framing.
  Assumes core_clk at 40 MHz; the serial clock is 8 core clocks (200 ns).
*/
`timescale 1ns/1ps

module fls_spi_host (
  input wire core_clk,
  output logic chipSelectN,
  output logic serialClk,
  output logic serialIn,
  input wire serialOut,
  input wire serialOutEn
);
  logic sawDrive; // Device drove data out during the last frame
  initial begin
    chipSelectN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
    sawDrive = 1'b0;
  end
  // ****
  // One frame: bytes out, extra stray bits, then bytes read back
  // ****
  task automatic frame(input logic [7:0] tx[$], input int extra, input int nRd,
                       output logic [7:0] rx[$]);
    int nTx;
    logic [7:0] sh;
    nTx = tx.size() * 8;
    rx = {};
    sh = 8'h00;
    sawDrive = 1'b0;
    @(posedge core_clk);
    chipSelectN <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < nTx + extra + nRd * 8; i++) begin
      // MSB first; outside the bytes the line toggles so it never looks held
      serialIn <= (i < nTx) ? tx[i / 8][7 - i % 8] : ~serialIn;
      repeat (4) @(posedge core_clk);
      serialClk <= 1'b1;
      repeat (4) @(posedge core_clk);
      // Sample late in the high phase, where data out has settled
      // A released line reads as the inverse, so a missing drive shows up
      sh = {sh[6:0], serialOutEn ? serialOut : ~serialOut};
      sawDrive = sawDrive | serialOutEn;
      if (i >= nTx + extra && (i - nTx - extra) % 8 == 7) begin
        rx.push_back(sh);
      end
      serialClk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    chipSelectN <= 1'b1;
    serialIn <= ~serialIn;
    repeat (8) @(posedge core_clk);
  endtask
endmodule // fls_spi_host

// ==== verification/fls_sequencer_tb_top.sv ====
/*
  Self-checking bench: wipes, page writes, protection, framing, code reads
  and deep sleep. Assumes the host model and bound checker are compiled.
*/
`timescale 1ns/1ps
`include "fls_sequencer_defs.vh"

module fls_sequencer_tb_top;
  localparam [7:0] SIG = 8'h4b;   // Arbitrary value
  localparam [7:0] MAKER = 8'h6e; // Arbitrary value
  localparam [7:0] PART = 8'h91;  // Arbitrary value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic protectLevelHi = 1'b0;
  logic protectLevelLo = 1'b0;
  logic [16:0] peekAddr = 17'h00000;
  wire chipSelectN, serialClk, serialIn, serialOut, serialOutEn;
  wire operationBusyFlag, writeArmedFlag, deepSleep;
  wire [7:0] peekData;
  logic [7:0] rxq[$]; // Bytes read in the last frame
  int n_mismatch = 0;
  int check_count = 0;
  always #12.5 core_clk = ~core_clk;
  // Short cycles keep the run brief; each still exceeds its region size
  fls_sequencer #(.SIGNATURE(SIG), .MAKER_CODE(MAKER), .PART_CODE(PART),
    .SMALL_WIPE_CYC(32'h1388), .LARGE_WIPE_CYC(32'h11170),
    .FULL_WIPE_CYC(32'h222e0), .PAGE_WRITE_CYC(32'h12c)) fls_sequencer_inst (
    .core_clk(core_clk), .rst_n(rst_n), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .protectLevelHi(protectLevelHi),
    .protectLevelLo(protectLevelLo), .operationBusyFlag(operationBusyFlag),
    .writeArmedFlag(writeArmedFlag), .deepSleep(deepSleep), .peekAddr(peekAddr),
    .peekData(peekData));
  fls_spi_host fls_spi_host_inst (.core_clk(core_clk), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn));
  // ****
  // Shared helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] tx[$], input int extra = 0, input int nRd = 0);
    fls_spi_host_inst.frame(tx, extra, nRd, rxq);
  endtask
  // Array byte appears one clock after the address
  task automatic peek(input logic [16:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    peekAddr <= a;
    repeat (2) @(posedge core_clk);
    chk(peekData, exp);
  endtask
  // Bounded wait on busy (sleep=0) or deep sleep (sleep=1)
  task automatic waitSig(input bit sleep, input logic val, input int max, output int n);
    n = 0;
    while ((sleep ? deepSleep : operationBusyFlag) !== val && n < max) begin
      @(posedge core_clk);
      n++;
    end
    chk(n < max, 1'b1);
  endtask
  task automatic t_arm;
    send('{`FLS_OP_WRITE_ARM});
    chk(writeArmedFlag, 1'b1);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_sector;
    int n;
    send('{`FLS_OP_SMALL_WIPE, 8'h00, 8'h12, 8'h34});
    chk(operationBusyFlag, 1'b0);
    t_arm();
    send('{`FLS_OP_SMALL_WIPE, 8'h00, 8'h12, 8'h34});
    chk(operationBusyFlag, 1'b1);
    // Requests during the cycle must not disturb it
    send('{`FLS_OP_PAGE_WRITE, 8'h00, 8'h10, 8'h00, 8'h00});
    send('{`FLS_OP_SLEEP_EXIT, 8'h00, 8'h00, 8'h00}, 0, 1);
    chk(fls_spi_host_inst.sawDrive, 1'b0);
    waitSig(0, 1'b0, 12000, n);
    chk(writeArmedFlag, 1'b0);
    peek(17'h01000, 8'hff);
    peek(17'h01fff, 8'hff);
  endtask
  task automatic t_protect;
    @(posedge core_clk);
    protectLevelLo <= 1'b1;
    t_arm();
    send('{`FLS_OP_SMALL_WIPE, 8'h01, 8'hf0, 8'h00});
    send('{`FLS_OP_LARGE_WIPE, 8'h01, 8'h00, 8'h00});
    send('{`FLS_OP_PAGE_WRITE, 8'h01, 8'hff, 8'h00, 8'h00});
    send('{`FLS_OP_FULL_WIPE});
    chk(operationBusyFlag, 1'b0);
    protectLevelLo <= 1'b0;
    protectLevelHi <= 1'b1;
    send('{`FLS_OP_FULL_WIPE});
    chk(operationBusyFlag, 1'b0);
    send('{`FLS_OP_SMALL_WIPE, 8'h01, 8'h00, 8'h00});
    chk(operationBusyFlag, 1'b0);
    // Both levels set shield the whole array, bottom sector too
    protectLevelLo <= 1'b1;
    send('{`FLS_OP_SMALL_WIPE, 8'h00, 8'h00, 8'h00});
    chk(operationBusyFlag, 1'b0);
    chk(writeArmedFlag, 1'b1);
    protectLevelHi <= 1'b0;
    protectLevelLo <= 1'b0;
    // Select rising off the byte boundary drops the command
    send('{`FLS_OP_PAGE_WRITE, 8'h00, 8'h11, 8'h00, 8'h00}, 3);
    send('{`FLS_OP_SMALL_WIPE, 8'h00, 8'h20, 8'h00}, 4);
    chk(operationBusyFlag, 1'b0);
    peek(17'h01100, 8'hff);
  endtask
  task automatic t_page;
    logic [7:0] q[$];
    logic [7:0] exp[5] = '{8'h06, 8'h07, 8'h08, 8'h00, 8'h0a};
    int n;
    q = '{`FLS_OP_PAGE_WRITE, 8'h00, 8'h10, 8'hfe};
    for (int k = 0; k < 258; k++) begin
      q.push_back(8'(k + 1));
    end
    send(q);
    chk(operationBusyFlag, 1'b1);
    waitSig(0, 1'b0, 1000, n);
    chk(writeArmedFlag, 1'b0);
    // Last 256 bytes kept, wrapped to the page start
    for (int c = 0; c < 256; c++) begin
      peek(17'h01000 + 17'(c), 8'(c + 3));
    end
    t_arm();
    send('{`FLS_OP_PAGE_WRITE, 8'h00, 8'h10, 8'h04, 8'hff, 8'h0f, 8'hf0});
    waitSig(0, 1'b0, 1000, n);
    for (int c = 0; c < 5; c++) begin
      peek(17'h01003 + 17'(c), exp[c]);
    end
  endtask
  task automatic t_id;
    for (int a = 0; a < 2; a++) begin
      send('{`FLS_OP_MAKER_PART_ID, 8'h00, 8'h00, 8'(a)}, 0, 3);
      chk(rxq[0], a ? PART : MAKER);
      chk(rxq[1], a ? MAKER : PART);
      chk(rxq[2], a ? PART : MAKER);
    end
  endtask
  task automatic t_sleep;
    int n;
    send('{`FLS_OP_SLEEP_ENTRY});
    repeat (90) @(posedge core_clk);
    chk(deepSleep, 1'b0);
    waitSig(1, 1'b1, 60, n);
    send('{`FLS_OP_WRITE_ARM});
    chk(writeArmedFlag, 1'b0);
    send('{`FLS_OP_MAKER_PART_ID, 8'h00, 8'h00, 8'h00}, 0, 1);
    chk(fls_spi_host_inst.sawDrive, 1'b0);
    send('{`FLS_OP_SLEEP_EXIT}, 1);
    repeat (400) @(posedge core_clk);
    chk(deepSleep, 1'b1);
    send('{`FLS_OP_SLEEP_EXIT, 8'h00, 8'h00, 8'h00}, 0, 2);
    chk(rxq[0], SIG);
    chk(rxq[1], SIG);
    // Select stays high until standby is reached
    waitSig(1, 1'b0, 400, n);
    chk(n > 250, 1'b1);
    t_arm();
  endtask
  task automatic results;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({operationBusyFlag, writeArmedFlag, deepSleep, serialOutEn}, 8'h00);
    t_sector();
    t_protect();
    t_page();
    t_id();
    t_sleep();
    results();
  end
  // Watchdog: the run needs under half this span
  initial begin
    #2000000;
    n_mismatch++;
    results();
  end
endmodule // fls_sequencer_tb_top
